// File: logic/hu_uart_defines.svh
`ifndef HU_UART_DEFINES_SVH
`define HU_UART_DEFINES_SVH
// Notes on behaviour
// - characters go out on serial_out and come in on serial_in
// - request_to_send_out tells the host whether we can take characters
// - flow control is selectable; when off both handshake lines are ignored
// - both handshake lines are active low: low means ready or permitted
// - bit rate configurable from 1200 bit/s to about 921 kbit/s
// - every frame carries exactly eight data bits
// - parity none, odd or even; appended after data and checked on receive
// - one or two stop bits per frame
// - reset format: 115.2 kbit/s, no flow control, 8 bits, no parity, 1 stop

// clock and bit rates
`define HU_CLK_HZ        25000000
`define HU_BAUD_DEFAULT  115200
`define HU_BAUD_MIN      1200
`define HU_BAUD_MAX      921600
`define HU_DIV_DEFAULT   (`HU_CLK_HZ / `HU_BAUD_DEFAULT)
`define HU_DIV_MIN       (`HU_CLK_HZ / `HU_BAUD_MAX)
`define HU_DIV_MAX       (`HU_CLK_HZ / `HU_BAUD_MIN)

// register byte offsets
`define HU_OFF_CTRL      12'h000
`define HU_OFF_BAUD      12'h004
`define HU_OFF_TXDATA    12'h008
`define HU_OFF_RXDATA    12'h00c
`define HU_OFF_STATUS    12'h010

// control fields and reset value
`define HU_CTRL_FLOW     0
`define HU_CTRL_PAR_LO   1
`define HU_CTRL_PAR_HI   2
`define HU_CTRL_STOP2    3
`define HU_CTRL_RESET    4'h0

// status fields
`define HU_STAT_TXRDY    0
`define HU_STAT_RXVAL    1
`define HU_STAT_PERR     2
`define HU_STAT_FERR     3
`define HU_STAT_OVR      4
`define HU_STAT_TXBUSY   5
`define HU_STAT_CTS      6
`endif

// File: logic/hu_pkg.sv
package hu_pkg;
  typedef enum logic [1:0] {
    HU_PAR_NONE = 2'h0,
    HU_PAR_ODD  = 2'h1,
    HU_PAR_EVEN = 2'h2
  } hu_parity_t;

  // gray coded along idle-start-data-parity-stop-stop2
  typedef enum logic [2:0] {
    HU_ST_IDLE   = 3'h0,
    HU_ST_START  = 3'h1,
    HU_ST_DATA   = 3'h3,
    HU_ST_PARITY = 3'h2,
    HU_ST_STOP   = 3'h6,
    HU_ST_STOP2  = 3'h7
  } hu_state_t;

  // parity bit for a character, shared by transmitter and receiver
  function automatic logic hu_parity_bit(input logic [7:0] d, input hu_parity_t p);
    return (p == HU_PAR_ODD) ? ~^d : ^d;
  endfunction
endpackage

// File: logic/hu_stream_if.sv
`timescale 1ns/1ps
interface hu_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: logic/hu_fifo2.sv
`timescale 1ns/1ps
module hu_fifo2 (
  input  wire logic  pclk,
  input  wire logic  presetn,
  hu_stream_if.snk   wr_s,
  hu_stream_if.src   rd_s,
  output logic [1:0] count
);
  import hu_pkg::*;
  logic [7:0] mem_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] cnt_reg;
  logic       push;
  logic       pop;

  // handshakes
  assign wr_s.ready = (cnt_reg != 2'h2);
  assign rd_s.valid = (cnt_reg != 2'h0);
  assign rd_s.data  = mem_reg[rd_ptr_reg];
  assign count      = cnt_reg;
  assign push       = wr_s.valid && wr_s.ready;
  assign pop        = rd_s.valid && rd_s.ready;

  // storage and pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= wr_s.data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 2'h1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_reg <= 2'h2) else $error("buffer count above two");
  a_fifo_head_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_s.valid && !rd_s.ready) |=> rd_s.valid && $stable(rd_s.data))
    else $error("stalled head word changed");
endmodule

// File: logic/hu_tx.sv
`timescale 1ns/1ps
module hu_tx (
  input  wire logic              pclk,
  input  wire logic              presetn,
  hu_stream_if.snk               in_s,
  input  wire logic [15:0]       div,
  input  wire hu_pkg::hu_parity_t parity,
  input  wire logic              two_stop,
  input  wire logic              send_ok,
  output logic                   serial_out,
  output logic                   busy
);
  import hu_pkg::*;
  hu_state_t  state_reg;
  logic [15:0] cnt_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  shift_reg;
  logic        par_reg;
  logic        par_on_reg;
  logic        stop2_reg;

  // take a character only when idle and the host permits
  assign in_s.ready = (state_reg == HU_ST_IDLE) && send_ok;
  assign busy       = (state_reg != HU_ST_IDLE);

  // frame sequencer: start, eight data lsb first, parity, stop bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= HU_ST_IDLE;
      cnt_reg    <= 16'h0000;
      bit_reg    <= 3'h0;
      shift_reg  <= 8'h00;
      par_reg    <= 1'b0;
      par_on_reg <= 1'b0;
      stop2_reg  <= 1'b0;
      serial_out <= 1'b1;
    end else if (state_reg == HU_ST_IDLE) begin
      serial_out <= 1'b1;
      if (in_s.valid && in_s.ready) begin
        shift_reg  <= in_s.data;
        par_reg    <= hu_parity_bit(in_s.data, parity);
        par_on_reg <= (parity == HU_PAR_ODD) || (parity == HU_PAR_EVEN);
        stop2_reg  <= two_stop;
        serial_out <= 1'b0;
        cnt_reg    <= div - 16'h0001;
        state_reg  <= HU_ST_START;
      end
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end else begin
      cnt_reg <= div - 16'h0001;
      case (state_reg)
        HU_ST_START: begin
          serial_out <= shift_reg[0];
          shift_reg  <= {1'b0, shift_reg[7:1]};
          bit_reg    <= 3'h0;
          state_reg  <= HU_ST_DATA;
        end
        HU_ST_DATA: begin
          if (bit_reg == 3'h7) begin
            serial_out <= par_on_reg ? par_reg : 1'b1;
            state_reg  <= par_on_reg ? HU_ST_PARITY : HU_ST_STOP;
          end else begin
            serial_out <= shift_reg[0];
            shift_reg  <= {1'b0, shift_reg[7:1]};
            bit_reg    <= bit_reg + 3'h1;
          end
        end
        HU_ST_PARITY: begin
          serial_out <= 1'b1;
          state_reg  <= HU_ST_STOP;
        end
        HU_ST_STOP: begin
          state_reg <= stop2_reg ? HU_ST_STOP2 : HU_ST_IDLE;
        end
        default: begin
          state_reg <= HU_ST_IDLE;
        end
      endcase
    end
  end

  sequence s_tx_accept;
    state_reg == HU_ST_IDLE && in_s.valid && in_s.ready;
  endsequence
  sequence s_tx_last_data;
    state_reg == HU_ST_DATA && cnt_reg == 16'h0000 && bit_reg == 3'h7;
  endsequence

  a_tx_start_bit: assert property (@(posedge pclk) disable iff (!presetn)
    s_tx_accept |=> !serial_out && state_reg == HU_ST_START)
    else $error("start bit not sent after accept");
  a_tx_cts_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == HU_ST_IDLE && !send_ok) |=> state_reg == HU_ST_IDLE && serial_out)
    else $error("character begun without permission");
  a_tx_parity_out: assert property (@(posedge pclk) disable iff (!presetn)
    (s_tx_last_data and par_on_reg) |=> state_reg == HU_ST_PARITY && serial_out == par_reg)
    else $error("parity bit missing after data");
  a_tx_eight_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (s_tx_last_data and !par_on_reg) |=> state_reg == HU_ST_STOP && serial_out)
    else $error("data field not eight bits");
  a_tx_two_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == HU_ST_STOP && cnt_reg == 16'h0000) |=>
      (state_reg == HU_ST_STOP2) == stop2_reg && serial_out)
    else $error("stop bit count wrong");
endmodule

// File: logic/hu_uart.sv
`timescale 1ns/1ps
`include "hu_uart_defines.svh"
module hu_uart (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             serial_out,
  input  wire logic        serial_in,
  output logic             request_to_send_out,
  input  wire logic        clear_to_send_in
);
  import hu_pkg::*;

  // address match, used for every register
  function automatic logic hu_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  hu_stream_if tx_wr_if ();
  hu_stream_if tx_rd_if ();
  hu_stream_if rx_wr_if ();
  hu_stream_if rx_rd_if ();

  logic        acc;
  logic        setup;
  logic        mapped;
  logic        wr_ok;
  logic        hit_ctrl;
  logic        hit_baud;
  logic        hit_tx;
  logic        hit_rx;
  logic        hit_stat;
  logic        flow_en_reg;
  hu_parity_t  parity_reg;
  logic        stop2_reg;
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic [31:0] rd_next;
  logic [31:0] prdata_reg;
  logic        perr_flag_reg;
  logic        ferr_flag_reg;
  logic        ovr_flag_reg;
  logic        rx_meta_reg;
  logic        rx_sync_reg;
  logic        cts_meta_reg;
  logic        cts_sync_reg;
  logic        send_ok;
  logic        tx_busy;
  logic [1:0]  rx_count;
  hu_state_t   rx_state_reg;
  logic [15:0] rx_cnt_reg;
  logic [2:0]  rx_bit_reg;
  logic [7:0]  rx_shift_reg;
  hu_parity_t  rx_par_reg;
  logic        rx_perr_reg;
  logic        rx_push_reg;
  logic [7:0]  rx_data_reg;
  logic        rx_push_perr_reg;
  logic        rx_push_ferr_reg;
  logic        rts_reg;

  // apb decode
  assign setup    = psel && !penable;
  assign acc      = psel && penable;
  assign hit_ctrl = hu_hit(paddr, `HU_OFF_CTRL);
  assign hit_baud = hu_hit(paddr, `HU_OFF_BAUD);
  assign hit_tx   = hu_hit(paddr, `HU_OFF_TXDATA);
  assign hit_rx   = hu_hit(paddr, `HU_OFF_RXDATA);
  assign hit_stat = hu_hit(paddr, `HU_OFF_STATUS);
  assign mapped   = hit_ctrl || hit_baud || hit_tx || hit_rx || hit_stat;

  // transmit data enters the buffer; a full buffer holds the bus in access
  assign tx_wr_if.valid = acc && pwrite && hit_tx;
  assign tx_wr_if.data  = pwdata[7:0];
  assign pready         = !(tx_wr_if.valid && !tx_wr_if.ready);
  assign pslverr        = acc && !mapped;
  assign wr_ok          = acc && pwrite && pready && mapped;
  assign prdata         = prdata_reg;

  // receive data leaves the buffer on a completed read of the data register
  assign rx_rd_if.ready = acc && !pwrite && hit_rx;

  // clamp the divisor to the supported bit-rate range
  always_comb begin
    div_next = pwdata[15:0];
    if (pwdata[15:0] < 16'(`HU_DIV_MIN)) begin
      div_next = 16'(`HU_DIV_MIN);
    end else if (pwdata[15:0] > 16'(`HU_DIV_MAX)) begin
      div_next = 16'(`HU_DIV_MAX);
    end
  end

  // format and rate configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_en_reg <= 1'(`HU_CTRL_RESET >> `HU_CTRL_FLOW);
      parity_reg  <= HU_PAR_NONE;
      stop2_reg   <= 1'b0;
      div_reg     <= 16'(`HU_DIV_DEFAULT);
    end else if (wr_ok && hit_ctrl) begin
      flow_en_reg <= pwdata[`HU_CTRL_FLOW];
      parity_reg  <= hu_parity_t'(pwdata[`HU_CTRL_PAR_HI:`HU_CTRL_PAR_LO]);
      stop2_reg   <= pwdata[`HU_CTRL_STOP2];
    end else if (wr_ok && hit_baud) begin
      div_reg <= div_next;
    end
  end

  // read mux
  always_comb begin
    rd_next = 32'h0000_0000;
    case (1'b1)
      hit_ctrl: begin
        rd_next[`HU_CTRL_FLOW]                   = flow_en_reg;
        rd_next[`HU_CTRL_PAR_HI:`HU_CTRL_PAR_LO] = parity_reg;
        rd_next[`HU_CTRL_STOP2]                  = stop2_reg;
      end
      hit_baud: begin
        rd_next[15:0] = div_reg;
      end
      hit_rx: begin
        rd_next[7:0] = rx_rd_if.valid ? rx_rd_if.data : 8'h00;
      end
      hit_stat: begin
        rd_next[`HU_STAT_TXRDY]  = tx_wr_if.ready;
        rd_next[`HU_STAT_RXVAL]  = rx_rd_if.valid;
        rd_next[`HU_STAT_PERR]   = perr_flag_reg;
        rd_next[`HU_STAT_FERR]   = ferr_flag_reg;
        rd_next[`HU_STAT_OVR]    = ovr_flag_reg;
        rd_next[`HU_STAT_TXBUSY] = tx_busy;
        rd_next[`HU_STAT_CTS]    = cts_sync_reg;
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  // read data is captured in the setup phase and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= rd_next;
    end
  end

  // sticky error flags, write one to clear, a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_flag_reg <= 1'b0;
      ferr_flag_reg <= 1'b0;
      ovr_flag_reg  <= 1'b0;
    end else begin
      perr_flag_reg <= (perr_flag_reg && !(wr_ok && hit_stat && pwdata[`HU_STAT_PERR]))
                       || (rx_push_reg && rx_push_perr_reg);
      ferr_flag_reg <= (ferr_flag_reg && !(wr_ok && hit_stat && pwdata[`HU_STAT_FERR]))
                       || (rx_push_reg && rx_push_ferr_reg);
      ovr_flag_reg  <= (ovr_flag_reg && !(wr_ok && hit_stat && pwdata[`HU_STAT_OVR]))
                       || (rx_push_reg && !rx_wr_if.ready);
    end
  end

  // pin synchronisers, idle high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_reg  <= 1'b1;
      rx_sync_reg  <= 1'b1;
      cts_meta_reg <= 1'b1;
      cts_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg  <= serial_in;
      rx_sync_reg  <= rx_meta_reg;
      cts_meta_reg <= clear_to_send_in;
      cts_sync_reg <= cts_meta_reg;
    end
  end

  // permission to start a character: low cts, or flow control off
  assign send_ok = !flow_en_reg || !cts_sync_reg;

  // receiver: detect start, sample each bit at its middle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg     <= HU_ST_IDLE;
      rx_cnt_reg       <= 16'h0000;
      rx_bit_reg       <= 3'h0;
      rx_shift_reg     <= 8'h00;
      rx_par_reg       <= HU_PAR_NONE;
      rx_perr_reg      <= 1'b0;
      rx_push_reg      <= 1'b0;
      rx_data_reg      <= 8'h00;
      rx_push_perr_reg <= 1'b0;
      rx_push_ferr_reg <= 1'b0;
    end else begin
      rx_push_reg <= 1'b0;
      if (rx_state_reg == HU_ST_IDLE) begin
        if (!rx_sync_reg) begin
          rx_cnt_reg   <= div_reg >> 1;
          rx_par_reg   <= parity_reg;
          rx_perr_reg  <= 1'b0;
          rx_state_reg <= HU_ST_START;
        end
      end else if (rx_cnt_reg != 16'h0000) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= div_reg - 16'h0001;
        case (rx_state_reg)
          HU_ST_START: begin
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= rx_sync_reg ? HU_ST_IDLE : HU_ST_DATA;
          end
          HU_ST_DATA: begin
            rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= (rx_par_reg == HU_PAR_NONE || rx_par_reg == 2'h3) ?
                              HU_ST_STOP : HU_ST_PARITY;
            end
          end
          HU_ST_PARITY: begin
            rx_perr_reg  <= rx_sync_reg != hu_parity_bit(rx_shift_reg, rx_par_reg);
            rx_state_reg <= HU_ST_STOP;
          end
          HU_ST_STOP: begin
            rx_push_reg      <= 1'b1;
            rx_data_reg      <= rx_shift_reg;
            rx_push_perr_reg <= rx_perr_reg;
            rx_push_ferr_reg <= !rx_sync_reg;
            rx_state_reg     <= HU_ST_IDLE;
          end
          default: begin
            rx_state_reg <= HU_ST_IDLE;
          end
        endcase
      end
    end
  end

  assign rx_wr_if.valid = rx_push_reg;
  assign rx_wr_if.data  = rx_data_reg;

  // request to send: high (not ready) once the receive buffer holds a word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_reg <= 1'b0;
    end else begin
      rts_reg <= flow_en_reg && (rx_count != 2'h0);
    end
  end
  assign request_to_send_out = rts_reg;

  hu_fifo2 u_tx_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_s    (tx_wr_if),
    .rd_s    (tx_rd_if),
    .count   ()
  );

  hu_tx u_tx (
    .pclk       (pclk),
    .presetn    (presetn),
    .in_s       (tx_rd_if),
    .div        (div_reg),
    .parity     (parity_reg),
    .two_stop   (stop2_reg),
    .send_ok    (send_ok),
    .serial_out (serial_out),
    .busy       (tx_busy)
  );

  hu_fifo2 u_rx_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_s    (rx_wr_if),
    .rd_s    (rx_rd_if),
    .count   (rx_count)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rx_bad_parity;
    rx_state_reg == HU_ST_PARITY && rx_cnt_reg == 16'h0000 &&
      (rx_sync_reg != hu_parity_bit(rx_shift_reg, rx_par_reg));
  endsequence

  a_rts_ignored: assert property (!flow_en_reg |=> !request_to_send_out)
    else $error("rts asserted with flow control off");
  a_rts_not_ready: assert property ((flow_en_reg && rx_count != 2'h0) |=> request_to_send_out)
    else $error("rts low while receive buffer occupied");
  a_rts_ready_low: assert property ((flow_en_reg && rx_count == 2'h0) |=> !request_to_send_out)
    else $error("rts high while receive buffer empty");
  a_baud_in_range: assert property (div_reg >= 16'(`HU_DIV_MIN) && div_reg <= 16'(`HU_DIV_MAX))
    else $error("divisor outside supported range");
  a_cfg_held: assert property (!(wr_ok && hit_baud) |=> $stable(div_reg))
    else $error("divisor changed without a write");
  a_rx_eight_bits: assert property ((rx_state_reg == HU_ST_DATA && rx_cnt_reg == 16'h0000 &&
    rx_bit_reg == 3'h7) |=> rx_state_reg inside {HU_ST_PARITY, HU_ST_STOP})
    else $error("receiver data field not eight bits");
  a_rx_parity_flag: assert property (s_rx_bad_parity |=> rx_perr_reg)
    else $error("bad parity not flagged");
  a_tx_word_kept: assert property ((tx_wr_if.valid && tx_wr_if.ready) |=> tx_rd_if.valid)
    else $error("accepted transmit word not offered to transmitter");
endmodule

// File: tb/hu_host_model.sv
`timescale 1ns/1ps
module hu_host_model (
  input  wire logic pclk,
  input  wire logic serial_out,
  output logic      serial_in,
  output logic      clear_to_send_in
);
  // line rests high, sending permitted until the bench says otherwise
  initial begin
    serial_in = 1'b1;
    clear_to_send_in = 1'b0;
  end

  // permission toward the device's transmitter, low means go
  task set_cts(input logic v);
    clear_to_send_in <= v;
  endtask

  // one frame toward the device, parity optionally spoiled
  task send(input logic [7:0] d, input logic [1:0] par, input logic bad, input int stops,
            input int div);
    logic [11:0] f;
    int          n;
    f = (par == 2'h0) ? {3'h7, d, 1'b0} : {2'h3, ((par == 2'h1) ? ~^d : ^d) ^ bad, d, 1'b0};
    n = ((par == 2'h0) ? 10 : 11) + stops - 1;
    for (int i = 0; i < n; i++) begin
      serial_in <= f[i];
      repeat (div) @(posedge pclk);
    end
  endtask

  // one frame from the device, sampled mid bit; stp[1] is the bit after the first stop
  task recv(input logic [1:0] par, input int div, output logic [7:0] d, output logic pb,
            output logic [1:0] stp, output logic ok);
    int t;
    t = 0;
    pb = 1'b0;
    while (serial_out !== 1'b0 && t < 40 * div) begin
      @(negedge pclk);
      t++;
    end
    ok = (serial_out === 1'b0);
    repeat (div / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(negedge pclk);
      d[i] = serial_out;
    end
    if (par != 2'h0) begin
      repeat (div) @(negedge pclk);
      pb = serial_out;
    end
    repeat (div) @(negedge pclk);
    stp[0] = serial_out;
    repeat (div) @(negedge pclk);
    stp[1] = serial_out;
    @(posedge pclk);
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`include "hu_uart_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rdy, err;
  logic        serial_out, serial_in, request_to_send_out, clear_to_send_in, pb, ok, two;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  rb, d;
  logic [1:0]  stp;
  int          n_fail, check_count, lows;

  hu_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_out(serial_out), .serial_in(serial_in),
    .request_to_send_out(request_to_send_out), .clear_to_send_in(clear_to_send_in));
  hu_host_model host (.pclk(pclk), .serial_out(serial_out), .serial_in(serial_in),
    .clear_to_send_in(clear_to_send_in));

  // verdict and end of run
  task end_of_test;
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one apb transfer; answer sampled and taken at the rising edge that ends access
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      t++;
    end while (rdy !== 1'b1 && t < 5000);
    `CHK(rdy, 1'b1)
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  // reset format and idle levels
  task t_reset;
    `CHK(serial_out, 1'b1)
    `CHK(request_to_send_out, 1'b0)
    apb(0, `HU_OFF_CTRL, 32'h0);
    `CHK(rd[3:0], 4'h0)
    `CHK(err, 1'b0)
    apb(0, `HU_OFF_BAUD, 32'h0);
    `CHK(rd[15:0], 16'h00d9)
    apb(0, `HU_OFF_STATUS, 32'h0);
    `CHK(rd[1:0], 2'h1)
  endtask

  // default format both ways, handshake lines ignored while flow is off
  task t_default;
    host.set_cts(1'b1);
    apb(1, `HU_OFF_TXDATA, 32'h0000_00a5);
    host.recv(2'h0, 217, rb, pb, stp, ok);
    `CHK(ok, 1'b1)
    `CHK(rb, 8'ha5)
    `CHK(stp[0], 1'b1)
    host.set_cts(1'b0);
    host.send(8'h5a, 2'h0, 1'b0, 1, 217);
    repeat (4) @(posedge pclk);
    `CHK(request_to_send_out, 1'b0)
    apb(0, `HU_OFF_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h5a)
  endtask

  // every parity mode and both stop counts, back to back frames at the fastest rate
  task t_format;
    apb(1, `HU_OFF_BAUD, 32'h0000_001b);
    for (int p = 0; p < 3; p++) begin
      d = 8'h3c + 8'(p);
      two = (p != 1);
      apb(1, `HU_OFF_CTRL, {28'h0, two, 2'(p), 1'b0});
      apb(1, `HU_OFF_TXDATA, {24'h0, d});
      apb(1, `HU_OFF_TXDATA, {24'h0, ~d});
      host.recv(2'(p), 27, rb, pb, stp, ok);
      `CHK(rb, d)
      if (p != 0) `CHK(pb, (p == 1) ? ~^d : ^d)
      `CHK(stp, {two, 1'b1})
      repeat (400) @(posedge pclk);
      host.send(d, 2'(p), 1'b0, two ? 2 : 1, 27);
      repeat (4) @(posedge pclk);
      apb(0, `HU_OFF_RXDATA, 32'h0);
      `CHK(rd[7:0], d)
      apb(0, `HU_OFF_STATUS, 32'h0);
      `CHK(rd[3:2], 2'h0)
    end
  endtask

  // spoiled parity is flagged, character kept, flag cleared by writing one
  task t_parity_err;
    apb(1, `HU_OFF_CTRL, 32'h0000_0002);
    host.send(8'h96, 2'h1, 1'b1, 1, 27);
    repeat (4) @(posedge pclk);
    apb(0, `HU_OFF_STATUS, 32'h0);
    `CHK(rd[2], 1'b1)
    apb(0, `HU_OFF_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h96)
    apb(1, `HU_OFF_STATUS, 32'h0000_0004);
    apb(0, `HU_OFF_STATUS, 32'h0);
    `CHK(rd[2], 1'b0)
  endtask

  // flow control: held by cts high, rts raised while a character waits
  task t_flow;
    apb(1, `HU_OFF_CTRL, 32'h0000_0001);
    host.set_cts(1'b1);
    apb(1, `HU_OFF_TXDATA, 32'h0000_0081);
    lows = 0;
    repeat (300) begin
      @(negedge pclk);
      if (serial_out !== 1'b1) lows++;
    end
    `CHK(lows, 0)
    @(posedge pclk);
    apb(0, `HU_OFF_STATUS, 32'h0);
    `CHK(rd[6:5], 2'h2)
    host.set_cts(1'b0);
    host.recv(2'h0, 27, rb, pb, stp, ok);
    `CHK(rb, 8'h81)
    host.send(8'h42, 2'h0, 1'b0, 1, 27);
    repeat (4) @(posedge pclk);
    `CHK(request_to_send_out, 1'b1)
    apb(0, `HU_OFF_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h42)
    repeat (3) @(posedge pclk);
    `CHK(request_to_send_out, 1'b0)
  endtask

  // unmapped address answers with an error and reads zero
  task t_unmapped;
    apb(0, 12'h020, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
  endtask

  // parity code three acts as none; a low stop bit and a third unread word are flagged
  task t_errors;
    apb(1, `HU_OFF_CTRL, 32'h0000_0006);
    host.send(8'h01, 2'h1, 1'b0, 1, 27);
    host.send(8'h11, 2'h0, 1'b0, 1, 27);
    host.send(8'h22, 2'h0, 1'b0, 1, 27);
    repeat (4) @(posedge pclk);
    apb(0, `HU_OFF_STATUS, 32'h0);
    `CHK(rd[4:2], 3'h6)
    apb(0, `HU_OFF_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h01)
    apb(0, `HU_OFF_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h11)
    apb(1, `HU_OFF_STATUS, 32'h0000_001c);
    apb(0, `HU_OFF_STATUS, 32'h0);
    `CHK(rd[4:1], 4'h0)
  endtask

  // free running clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // hang guard, well beyond the expected run
  initial begin
    #2400000;
    n_fail++;
    end_of_test;
  end

  // reset then the scenarios in turn
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; n_fail = 0; check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_default;
    t_format;
    t_parity_err;
    t_flow;
    t_unmapped;
    t_errors;
    end_of_test;
  end
endmodule
